/* src/pbt_pkg.sv */
// pbt_pkg: offsets, reset values and widths for the prescaler and base timer
// assumes: APB slave with 32-bit data and one clock, mclk at 100 MHz
package pbt_pkg;
    localparam int          PBT_AW        = 12;
    // printed offsets are register indices; byte address is index times four
    localparam logic [9:0]  PRESCALE_IDX  = 10'h029;
    localparam logic [9:0]  TICK_EN_IDX   = 10'h02a;
    localparam logic [9:0]  TICK_FLAG_IDX = 10'h02b;
    localparam logic [9:0]  ADJ_RELOAD_IDX = 10'h02c;
    localparam logic [9:0]  PENDING_IDX   = 10'h02d;
    localparam int          CLEAR_BIT     = 7;
    localparam int          RUN_BIT       = 6;
    localparam int          NUM_SRC       = 6;
    localparam int          NUM_RATES     = 8;
    localparam int          NUM_FIXED     = 7;
    localparam int          TAP_BIT [NUM_SRC] = '{0, 1, 2, 3, 5, 7};
    localparam logic [7:0]  PRESCALE_RST  = 8'h00;
    localparam logic [7:0]  TICK_EN_RST   = 8'h00;
    localparam logic [7:0]  TICK_FLAG_RST = 8'h00;
    localparam logic [7:0]  ADJ_RELOAD_RST = 8'hff;
    localparam int          BASE_DIV_DEF  = 1000;
    localparam logic [4:0]  TICK_PRIORITY = 5'h0f;
    localparam logic [15:0] TICK_VEC_LO   = 16'h7fec;
    localparam logic [15:0] TICK_VEC_HI   = 16'h7fed;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_SETUP  = 2'b01,
        APB_ACCESS = 2'b10
    } pbt_apb_state_type;
endpackage : pbt_pkg

/* src/pbt_rate_chain.sv */
// pbt_rate_chain: divider plus cascaded binary sub-counters for fixed rates
// assumes: single clock domain, pulses are one mclk cycle wide
`timescale 1ns/1ps
module pbt_rate_chain
    import pbt_pkg::*;
#(
    parameter int BASE_DIV = BASE_DIV_DEF,
    parameter int NFIX     = NUM_FIXED
) (
    input  wire logic            mclk,
    input  wire logic            reset_n,
    output logic                 baseTick,
    output logic [NFIX-1:0]      fixedTick
);
    // refuse settings that the 16-bit divider or the chain cannot serve
    if (BASE_DIV < 2 || BASE_DIV > 65536 || NFIX < 1) begin : g_bad_param
        $error("pbt_rate_chain: bad parameters");
    end

    logic [15:0]     divCnt_r;
    logic [NFIX-1:0] stage_r;
    logic [NFIX:0]   carry;

    // front divider sets the base tick period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r <= 16'h0000;
            baseTick <= 1'b0;
        end else begin
            baseTick <= (divCnt_r == 16'(BASE_DIV - 1));
            divCnt_r <= (divCnt_r == 16'(BASE_DIV - 1)) ? 16'h0000 : divCnt_r + 16'h0001;
        end
    end

    assign carry[0] = baseTick;

    // each sub-counter halves the rate of the one before it
    genvar i;
    generate
        for (i = 0; i < NFIX; i++) begin : g_stage
            assign carry[i+1] = carry[i] & stage_r[i];
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    stage_r[i]   <= 1'b0;
                    fixedTick[i] <= 1'b0;
                end else begin
                    if (carry[i]) stage_r[i] <= ~stage_r[i];
                    fixedTick[i] <= carry[i+1];
                end
            end
        end
    endgenerate
endmodule : pbt_rate_chain

/* src/pbt_adj_counter.sv */
// pbt_adj_counter: sub-counter with software reload for the adjustable rate
// assumes: step is a one-cycle pulse, reload may change at any time
`timescale 1ns/1ps
module pbt_adj_counter #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         step,
    input  wire logic [W-1:0] reloadVal,
    output logic              tickOut
);
    // refuse widths the reload port cannot serve
    if (W < 1 || W > 16) begin : g_bad_width
        $error("pbt_adj_counter: bad width");
    end

    logic [W-1:0] cnt_r;

    // wraps after reloadVal+1 steps; a reload lowered below cnt wraps at the top
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r   <= '0;
            tickOut <= 1'b0;
        end else begin
            tickOut <= step && (cnt_r == reloadVal);
            if (step) cnt_r <= (cnt_r == reloadVal) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule : pbt_adj_counter

/* src/pbt_timer_top.sv */
// pbt_timer_top: prescaler for the 12-bit timers and the base tick timer
// assumes: APB master per the protocol, interrupt controller on tickIrq/tickPending
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pbt_timer_top
    import pbt_pkg::*;
#(
    parameter int BASE_DIV = BASE_DIV_DEF
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [PBT_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [NUM_SRC-1:0]     timerClkTick,
    output logic [NUM_RATES-1:0]   rateTick,
    output logic                   tickIrq,
    output logic                   tickPending,
    output logic                   tickWake,
    input  wire logic              serviceEnter,
    output logic [4:0]             tickPriority,
    output logic [15:0]            tickVector
);
    // the divider counter is 16 bits wide, so larger divisions cannot be served
    if (BASE_DIV < 2 || BASE_DIV > 65536) begin : g_bad_div
        $error("pbt_timer_top: BASE_DIV out of range");
    end

    pbt_apb_state_type apbState_r;
    pbt_apb_state_type apbState_nxt;
    logic [7:0]           prescaleCnt_r;
    logic                 prescaleRun_r;
    logic [7:0]           tickEn_r;
    logic [7:0]           tickFlag_r;
    logic [7:0]           adjReload_r;
    logic                 irqPending_r;
    logic [NUM_SRC-1:0]   srcTick_r;
    logic                 baseTick;
    logic [NUM_FIXED-1:0] fixedTick;
    logic                 adjTick;
    logic [9:0]           regIdx;
    logic                 selPrescale;
    logic                 selTickEn;
    logic                 selTickFlag;
    logic                 selAdj;
    logic                 selPending;
    logic                 mapped;
    logic                 wrAccess;
    logic                 rdSetup;
    logic [7:0]           enabledEvt;
    logic [7:0]           newFlags;
    logic [7:0]           flagClear;

    // address decode on word index
    assign regIdx      = paddr[PBT_AW-1:2];
    assign selPrescale = (regIdx == PRESCALE_IDX);
    assign selTickEn   = (regIdx == TICK_EN_IDX);
    assign selTickFlag = (regIdx == TICK_FLAG_IDX);
    assign selAdj      = (regIdx == ADJ_RELOAD_IDX);
    assign selPending  = (regIdx == PENDING_IDX);
    assign mapped      = selPrescale | selTickEn | selTickFlag | selAdj | selPending;

    // zero wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign wrAccess = psel & penable & pwrite & mapped;
    assign rdSetup  = psel & ~penable & ~pwrite;

    // phase tracker; feeds the check that every access follows a setup cycle
    always_comb begin
        case (apbState_r)
            APB_IDLE:   apbState_nxt = psel ? APB_SETUP : APB_IDLE;
            APB_SETUP:  apbState_nxt = APB_ACCESS;
            APB_ACCESS: apbState_nxt = psel && !penable ? APB_SETUP : (psel ? APB_ACCESS : APB_IDLE);
            default:    apbState_nxt = APB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) apbState_r <= APB_IDLE;
        else          apbState_r <= apbState_nxt;
    end

    // read data captured at the setup edge so prdata comes from flops;
    // the counter value seen is the one from the setup cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            if (selPrescale)      prdata <= {24'h000000, prescaleCnt_r};
            else if (selTickEn)   prdata <= {24'h000000, tickEn_r};
            else if (selTickFlag) prdata <= {24'h000000, tickFlag_r};
            else if (selAdj)      prdata <= {24'h000000, adjReload_r};
            else if (selPending)  prdata <= {31'h0, irqPending_r};
            else                  prdata <= 32'h0000_0000;
        end
    end

    // prescale run bit; only bit 6 of a write is stored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)                   prescaleRun_r <= 1'b0;
        else if (wrAccess && selPrescale) prescaleRun_r <= pwdata[RUN_BIT];
    end

    // prescale counter: clear request beats counting in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)                                         prescaleCnt_r <= PRESCALE_RST;
        else if (wrAccess && selPrescale && pwdata[CLEAR_BIT]) prescaleCnt_r <= 8'h00;
        else if (prescaleRun_r)                               prescaleCnt_r <= prescaleCnt_r + 8'h01;
    end

    // timer sources: one pulse each time the low stages up to a tap wrap
    genvar s;
    generate
        for (s = 0; s < NUM_SRC; s++) begin : g_src
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) srcTick_r[s] <= 1'b0;
                else          srcTick_r[s] <= prescaleRun_r && (&prescaleCnt_r[TAP_BIT[s]:0]);
            end
        end
    endgenerate
    assign timerClkTick = srcTick_r;

    // seven fixed rates from the divider chain
    pbt_rate_chain #(
        .BASE_DIV (BASE_DIV),
        .NFIX     (NUM_FIXED)
    ) u_chain (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .baseTick  (baseTick),
        .fixedTick (fixedTick)
    );

    // eighth, adjustable rate steps on the base tick
    pbt_adj_counter #(
        .W (8)
    ) u_adj (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .step      (baseTick),
        .reloadVal (adjReload_r),
        .tickOut   (adjTick)
    );

    assign rateTick = {adjTick, fixedTick};

    // enable and reload registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tickEn_r    <= TICK_EN_RST;
            adjReload_r <= ADJ_RELOAD_RST;
        end else if (wrAccess) begin
            if (selTickEn) tickEn_r    <= pwdata[7:0];
            if (selAdj)    adjReload_r <= pwdata[7:0];
        end
    end

    // an overflow only counts when its enable bit is set
    assign enabledEvt = rateTick & tickEn_r;
    assign flagClear  = (wrAccess && selTickFlag) ? pwdata[7:0] : 8'h00;
    // a flag still set swallows a repeat of its rate until software clears it
    assign newFlags   = enabledEvt & ~tickFlag_r;

    // sticky flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) tickFlag_r <= TICK_FLAG_RST;
        else          tickFlag_r <= (tickFlag_r & ~flagClear) | enabledEvt;
    end

    // interrupt level: any enabled flag still awaiting service
    assign tickIrq = |(tickFlag_r & tickEn_r);

    // pending bit toward the cpu; zero write or service entry clears, set wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)           irqPending_r <= 1'b0;
        else if (|newFlags)     irqPending_r <= 1'b1;
        else if (serviceEnter)  irqPending_r <= 1'b0;
        else if (wrAccess && selPending && !pwdata[0]) irqPending_r <= 1'b0;
    end

    assign tickPending  = irqPending_r;
    assign tickWake     = irqPending_r;
    assign tickPriority = TICK_PRIORITY;
    assign tickVector   = serviceEnter ? TICK_VEC_HI : TICK_VEC_LO;

    // checks
    apb_phase_a: assert property (@(posedge mclk) disable iff (!reset_n)
        psel && penable |-> apbState_r == APB_SETUP)
        else $error("access phase without a setup cycle");

    prescale_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        wrAccess && selPrescale && pwdata[CLEAR_BIT] |=> prescaleCnt_r == 8'h00)
        else $error("prescale clear did not zero the counter");

    prescale_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
        prescaleRun_r && !(wrAccess && selPrescale) |=> prescaleCnt_r == $past(prescaleCnt_r) + 8'h01)
        else $error("prescale counter did not step while running");

    prescale_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !prescaleRun_r && !(wrAccess && selPrescale) |=> $stable(prescaleCnt_r))
        else $error("prescale counter moved while stopped");

    prescale_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
        psel && !penable && !pwrite && selPrescale ##1 psel && penable
        |-> prdata == {24'h000000, $past(prescaleCnt_r)})
        else $error("prescale read did not return the counter");

    source_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
        timerClkTick != '0 |-> $past(prescaleRun_r) && $past(prescaleCnt_r[0]))
        else $error("timer source pulsed without counting");

    flag_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
        enabledEvt != 8'h00 |=> (tickFlag_r & $past(enabledEvt)) == $past(enabledEvt))
        else $error("enabled overflow did not set its flag");

    flag_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        flagClear != 8'h00 |=> (tickFlag_r & $past(flagClear & ~enabledEvt)) == 8'h00
        && (tickFlag_r & ~$past(flagClear)) == ($past(tickFlag_r | enabledEvt) & ~$past(flagClear)))
        else $error("flag clear hit the wrong bits");

    flag_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tickFlag_r & ~$past(tickFlag_r)) != 8'h00 |-> ((tickFlag_r & ~$past(tickFlag_r)) & ~$past(tickEn_r)) == 8'h00)
        else $error("flag rose for a disabled rate");

    irq_raise_a: assert property (@(posedge mclk) disable iff (!reset_n)
        newFlags != 8'h00 && tickEn_r == $past(tickEn_r) |=> tickIrq || $past(wrAccess && selTickEn))
        else $error("enabled flag did not raise the interrupt");

    pending_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
        newFlags != 8'h00 |=> tickPending && tickWake)
        else $error("pending bit not set by new event");

    pending_svc_a: assert property (@(posedge mclk) disable iff (!reset_n)
        serviceEnter && newFlags == 8'h00 |=> !tickPending)
        else $error("service entry did not clear pending");

    prescale_clear_c: cover property (@(posedge mclk) disable iff (!reset_n)
        wrAccess && selPrescale && pwdata[CLEAR_BIT] && prescaleCnt_r != 8'h00);

    flag_race_c: cover property (@(posedge mclk) disable iff (!reset_n)
        (flagClear & enabledEvt) != 8'h00);

    service_c: cover property (@(posedge mclk) disable iff (!reset_n)
        tickPending ##1 serviceEnter);

    adj_tick_c: cover property (@(posedge mclk) disable iff (!reset_n)
        adjTick && tickEn_r[NUM_RATES-1]);

endmodule : pbt_timer_top

/* dv/pbt_irq_partner.sv */
// pbt_irq_partner: interrupt controller and 12-bit timer stand-in beside the tick block
// assumes: one mclk domain, pending is a level, service entry is a one-cycle pulse
`timescale 1ns/1ps
module pbt_irq_partner
    import pbt_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire logic                      tickPending,
    input  wire logic [15:0]               tickVector,
    input  wire logic [4:0]                tickPriority,
    input  wire logic [NUM_SRC-1:0]        timerClkTick,
    input  wire logic [NUM_RATES-1:0]      rateTick,
    input  wire logic                      autoAck,
    input  wire logic [3:0]                ackDelay,
    output logic                           serviceEnter,
    output logic [15:0]                    ackCount,
    output logic [15:0]                    lastVector,
    output logic [4:0]                     lastPriority,
    output logic [NUM_SRC-1:0][15:0]       srcCount,
    output logic [NUM_RATES-1:0][15:0]     rateCount
);
    logic [1:0] ackState_r;
    logic [3:0] waitCnt_r;

    // latency is programmable so both prompt and slow handlers are exercised
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackState_r   <= 2'h0;
            waitCnt_r    <= 4'h0;
            serviceEnter <= 1'b0;
        end else begin
            serviceEnter <= 1'b0;
            case (ackState_r)
                2'h0: if (autoAck && tickPending) begin
                    ackState_r <= 2'h1;
                    waitCnt_r  <= ackDelay;
                end
                2'h1: if (waitCnt_r == 4'h0) begin
                    serviceEnter <= 1'b1; // entering the routine clears pending
                    ackState_r   <= 2'h2;
                end else begin
                    waitCnt_r <= waitCnt_r - 4'h1;
                end
                // wait for pending to drop so one event is serviced once
                default: if (!tickPending && !serviceEnter) ackState_r <= 2'h0;
            endcase
        end
    end

    // what the controller fetched on entry
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackCount     <= 16'h0;
            lastVector   <= 16'h0;
            lastPriority <= 5'h0;
        end else if (serviceEnter) begin
            ackCount     <= ackCount + 16'h1;
            lastVector   <= tickVector;   // vector pair fetch
            lastPriority <= tickPriority; // arbitration level
        end
    end

    // timers count their source pulses; the bench compares windows of these
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            srcCount  <= '0;
            rateCount <= '0;
        end else begin
            for (int s = 0; s < NUM_SRC; s++) if (timerClkTick[s]) srcCount[s] <= srcCount[s] + 16'h1;
            for (int r = 0; r < NUM_RATES; r++) if (rateTick[r]) rateCount[r] <= rateCount[r] + 16'h1;
        end
    end
endmodule : pbt_irq_partner

/* dv/testbench.sv */
// testbench: directed scenarios for the prescaler and tick timer over APB
// assumes: zero-wait APB slave, partner model acting as interrupt controller
`timescale 1ns/1ps
module testbench
    import pbt_pkg::*;
;
    localparam int          TB_DIV      = 4;
    localparam logic [11:0] ADDR_PRS    = {PRESCALE_IDX, 2'b00};
    localparam logic [11:0] ADDR_EN     = {TICK_EN_IDX, 2'b00};
    localparam logic [11:0] ADDR_FLAG   = {TICK_FLAG_IDX, 2'b00};
    localparam logic [11:0] ADDR_RELOAD = {ADJ_RELOAD_IDX, 2'b00};
    localparam logic [11:0] ADDR_PEND   = {PENDING_IDX, 2'b00};

    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
    logic tickIrq, tickPending, tickWake, serviceEnter, autoAck;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NUM_SRC-1:0] timerClkTick;
    logic [NUM_RATES-1:0] rateTick;
    logic [4:0] tickPriority, lastPriority;
    logic [15:0] tickVector, ackCount, lastVector;
    logic [3:0] ackDelay;
    logic [NUM_SRC-1:0][15:0] srcCount;
    logic [NUM_RATES-1:0][15:0] rateCount;
    int errCount, cmpCount;

    pbt_timer_top #(.BASE_DIV(TB_DIV)) i_pbt_timer_top (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerClkTick(timerClkTick), .rateTick(rateTick), .tickIrq(tickIrq),
        .tickPending(tickPending), .tickWake(tickWake), .serviceEnter(serviceEnter),
        .tickPriority(tickPriority), .tickVector(tickVector));
    pbt_irq_partner i_pbt_irq_partner (.mclk(mclk), .reset_n(reset_n), .tickPending(tickPending),
        .tickVector(tickVector), .tickPriority(tickPriority), .timerClkTick(timerClkTick), .rateTick(rateTick),
        .autoAck(autoAck), .ackDelay(ackDelay), .serviceEnter(serviceEnter), .ackCount(ackCount),
        .lastVector(lastVector), .lastPriority(lastPriority), .srcCount(srcCount), .rateCount(rateCount));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check(32'(n), 32'h0);
        #1;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask : rd

    // bounded wait on the interrupt line or the pending bit
    task automatic waitHigh(input bit pend);
        int n;
        n = 0;
        while ((pend ? tickPending : tickIrq) !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000) check(32'(n), 32'h0);
        #1;
    endtask : waitHigh

    task automatic testReset;
        logic [31:0] v;
        rd(ADDR_PRS, v);
        check(v, 32'(PRESCALE_RST));
        rd(ADDR_EN, v);
        check(v, 32'(TICK_EN_RST));
        rd(ADDR_FLAG, v);
        check(v, 32'(TICK_FLAG_RST));
        check(32'({tickIrq, tickPending}), 32'h0);
        check(32'(tickPriority), 32'(TICK_PRIORITY));
    endtask : testReset

    // clear plus run, 260 idle cycles, stop: 263 counts wrap to 7
    task automatic testPrescale;
        logic [31:0] v, a, b;
        wr(ADDR_PRS, 32'hc0);
        repeat (260) @(posedge mclk);
        wr(ADDR_PRS, 32'h00);
        rd(ADDR_PRS, v);
        check(v, 32'h07);
        wr(ADDR_PRS, 32'h40);
        rd(ADDR_PRS, a);
        rd(ADDR_PRS, b);
        check((b - a) & 32'hff, 32'h03);
        wr(ADDR_PRS, 32'h80);
        repeat (5) @(posedge mclk);
        rd(ADDR_PRS, v);
        check(v, 32'h00);
    endtask : testPrescale

    // any 512-cycle window holds a whole number of periods of every source
    task automatic testSources;
        logic [NUM_SRC-1:0][15:0] s0, s1;
        wr(ADDR_PRS, 32'h40);
        repeat (3) @(posedge mclk);
        s0 = srcCount;
        repeat (512) @(posedge mclk);
        s1 = srcCount;
        for (int s = 0; s < NUM_SRC; s++) check(32'(s1[s] - s0[s]), 32'(512 >> (TAP_BIT[s] + 1)));
        wr(ADDR_PRS, 32'h80);
    endtask : testSources

    // second pass retimes the adjustable rate; the wait lets an old reload run out
    task automatic testRates;
        logic [NUM_RATES-1:0][15:0] r0, r1;
        for (int k = 0; k < 2; k++) begin
            if (k == 1) wr(ADDR_RELOAD, 32'h03);
            repeat (1100) @(posedge mclk);
            r0 = rateCount;
            repeat (1024) @(posedge mclk);
            r1 = rateCount;
            for (int i = 0; i < NUM_RATES; i++)
                check(32'(r1[i] - r0[i]), (i == 7) ? 32'(1024 / (TB_DIV * (k ? 4 : 256)))
                    : 32'(1024 / (TB_DIV << (i + 1))));
        end
    endtask : testRates

    // each rate alone: raise, mask, zero-write keeps, one-write clears, serviced once
    task automatic testIrqLoop;
        logic [31:0] v;
        autoAck = 1'b1;
        for (int i = 0; i < NUM_RATES; i++) begin
            ackDelay = 4'(2 * i);
            wr(ADDR_EN, 32'h1 << i);
            waitHigh(1'b0);
            rd(ADDR_FLAG, v);
            check(v, 32'h1 << i);
            wr(ADDR_EN, 32'h0);
            check(32'(tickIrq), 32'h0);
            wr(ADDR_FLAG, 32'h0);
            rd(ADDR_FLAG, v);
            check(v, 32'h1 << i);
            wr(ADDR_FLAG, 32'h1 << i);
            rd(ADDR_FLAG, v);
            check(v, 32'h0);
            repeat (8) @(posedge mclk);
            check(32'(ackCount), 32'(i + 1));
            check(32'(tickPending), 32'h0);
        end
        check(32'(lastVector), 32'(TICK_VEC_HI));
        check(32'(lastPriority), 32'(TICK_PRIORITY));
    endtask : testIrqLoop

    // two rates ORed, no service taken, pending cleared by a zero write
    task automatic testOrPending;
        logic [31:0] v;
        autoAck = 1'b0;
        wr(ADDR_EN, 32'h81);
        waitHigh(1'b1);
        check(32'({tickIrq, tickWake}), 32'h3);
        repeat (16) @(posedge mclk);
        rd(ADDR_FLAG, v);
        check(v, 32'h81);
        rd(ADDR_PEND, v);
        check(v, 32'h1);
        wr(ADDR_PEND, 32'h0);
        repeat (32) @(posedge mclk);
        check(32'(tickPending), 32'h0);
        wr(ADDR_EN, 32'h0);
        rd(ADDR_PEND, v);
        check(v, 32'h0);
        wr(ADDR_FLAG, 32'hff);
        rd(ADDR_FLAG, v);
        check(v, 32'h0);
        check(32'(ackCount), 32'h8);
    endtask : testOrPending

    task automatic testUnmapped;
        logic [31:0] v;
        rd(12'hffc, v);
        check({v[30:0], lastErr}, 32'h1);
        wr(12'hffc, 32'hff);
        check(32'(lastErr), 32'h1);
        rd(ADDR_EN, v);
        check(v, 32'h0);
    endtask : testUnmapped

    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : giveVerdict

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        autoAck = 1'b0;
        ackDelay = 4'h0;
        errCount = 0;
        cmpCount = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        testReset;
        testPrescale;
        testSources;
        testRates;
        testIrqLoop;
        testOrPending;
        testUnmapped;
        giveVerdict;
    end

    // the run needs about 6k cycles; this limit only trips on a hang
    initial begin
        #300us;
        errCount++;
        giveVerdict;
    end
endmodule : testbench
